// ### core/output_channel.sv
// Decode of one function code into an output active level
`timescale 1ns/1ps
`include "outsel_regs.svh"

module output_channel
(
	input  wire outsel_pkg::func_code_t code,       // Stored function code
	input  wire logic                   heat_dem,   // Heating demanded
	input  wire logic                   cool_dem,   // Cooling demanded
	input  wire outsel_pkg::alarm_set_t alarm_act,  // Alarm active flags
	input  wire logic                   timer_end,  // Timer has timed out
	input  wire logic                   timer_run,  // Timer is running
	output wire logic                   active      // Output active level
);

	// ----------------------------------------------------------------
	// Code decode
	// ----------------------------------------------------------------
	// Disabled and unknown codes decode to nothing, so output is off
	wire logic sel_heat  = (code == `OFS_CODE_HEAT);
	wire logic sel_cool  = (code == `OFS_CODE_COOL);
	wire logic sel_a1    = (code == `OFS_CODE_ALARM1);
	wire logic sel_a2    = (code == `OFS_CODE_ALARM2);
	wire logic sel_a3    = (code == `OFS_CODE_ALARM3);
	wire logic sel_a1i   = (code == `OFS_CODE_ALARM1_INV);
	wire logic sel_a2i   = (code == `OFS_CODE_ALARM2_INV);
	wire logic sel_a3i   = (code == `OFS_CODE_ALARM3_INV);
	wire logic sel_tend  = (code == `OFS_CODE_TIMER_END);
	wire logic sel_trun  = (code == `OFS_CODE_TIMER_RUN);

	// ----------------------------------------------------------------
	// Source terms
	// ----------------------------------------------------------------
	// Control demands, normal sense
	wire logic term_ctrl = (sel_heat & heat_dem)             // RULE3
	                     | (sel_cool & cool_dem);            // RULE4
	// Alarms, normal sense
	wire logic term_alm  = (sel_a1 & alarm_act[0])
	                     | (sel_a2 & alarm_act[1])
	                     | (sel_a3 & alarm_act[2]);          // RULE7
	// Alarms, inverted sense: off while alarm active
	wire logic term_inv  = (sel_a1i & ~alarm_act[0])
	                     | (sel_a2i & ~alarm_act[1])
	                     | (sel_a3i & ~alarm_act[2]);        // RULE8
	// Timer status
	wire logic term_tmr  = (sel_tend & timer_end)            // RULE10
	                     | (sel_trun & timer_run);           // RULE11

	// Disabled code selects no term at all
	assign active = term_ctrl | term_alm | term_inv | term_tmr; // RULE2

endmodule : output_channel

// ### core/output_function_selector.sv
// Output function selector for the first and second discrete outputs
`timescale 1ns/1ps
`include "outsel_regs.svh"

// Overview of operation
// (RULE1) First defaults heat, second defaults disabled
// (RULE2) Disabled code holds output off always
// (RULE3) First output heat code follows heat demand
// (RULE4) First output cool code follows cool demand
// (RULE5) Second output heat code follows heat demand
// (RULE6) Second output cool code follows cool demand
// (RULE7) Normal alarm code: active while alarm active
// (RULE8) Inverted alarm code: inactive while alarm active
// (RULE9) Analogue second output: zero current when inverted
// (RULE10) Timer end code: active once timed out
// (RULE11) Timer run code: active while running
// (RULE12) First stage maps to relay or logic
// (RULE13) Codes persist, changed only at configuration level; a valid saved-code restore also loads them at any level
module output_function_selector
(
	input  wire logic                    clock,               // 100 MHz clock
	input  wire logic                    srst,                // Sync reset, high
	input  wire logic                    clock_en,            // Freezes state when low
	input  wire logic                    heat_demand,         // Loop heat demand
	input  wire logic                    cool_demand,         // Loop cool demand
	input  wire outsel_pkg::alarm_set_t  alarm_active,        // Alarm 3..1 active
	input  wire logic                    timer_timed_out,     // Timer end status
	input  wire logic                    timer_running,       // Timer run status
	input  wire logic                    config_level,        // Config access level
	input  wire logic                    cfg_write,           // Setting write strobe
	input  wire outsel_pkg::out_select_t cfg_target,          // Output addressed
	input  wire outsel_pkg::func_code_t  cfg_code,            // Code to store
	input  wire logic                    restore_valid,       // Saved codes present
	input  wire outsel_pkg::func_code_t  restore_first,       // Saved first code
	input  wire outsel_pkg::func_code_t  restore_second,      // Saved second code
	input  wire logic                    first_is_logic_pin,  // Strap: logic drive fitted
	input  wire logic                    second_is_analog_pin,// Strap: analogue fitted
	output logic                         first_relay_energise,// First relay coil
	output logic                         first_logic_drive,   // First logic drive
	output logic                         second_relay_energise,// Second relay coil
	output logic                         second_current_on,   // Second current on
	output outsel_pkg::func_code_t       first_output_function_setting,  // Stored
	output outsel_pkg::func_code_t       second_output_function_setting, // Stored
	output logic                         cfg_refused          // Write refused pulse
);

	// ----------------------------------------------------------------
	// Strap synchronisers
	// ----------------------------------------------------------------
	logic first_logic_meta;     // First stage of logic strap
	logic first_logic_sync;     // Synchronised logic strap
	logic second_analog_meta;   // First stage of analogue strap
	logic second_analog_sync;   // Synchronised analogue strap

	// Two flops per strap pin; only the second is read by logic
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			first_logic_meta   <= 1'b0;
			first_logic_sync   <= 1'b0;
			second_analog_meta <= 1'b0;
			second_analog_sync <= 1'b0;
		end
		else if (clock_en)
		begin
			first_logic_meta   <= first_is_logic_pin;
			first_logic_sync   <= first_logic_meta;
			second_analog_meta <= second_is_analog_pin;
			second_analog_sync <= second_analog_meta;
		end
	end

	// ----------------------------------------------------------------
	// Setting write decode
	// ----------------------------------------------------------------
	// Code must be one of the defined functions
	wire logic code_known   = (cfg_code <= `OFS_CODE_LAST);
	// Writes only count from the configuration access level
	wire logic write_ok     = cfg_write & config_level & code_known;   // RULE13
	wire logic write_bad    = cfg_write & ~write_ok;
	wire logic write_first  = write_ok & (cfg_target == outsel_pkg::SEL_FIRST);
	wire logic write_second = write_ok & (cfg_target == outsel_pkg::SEL_SECOND);
	// Saved codes are accepted only if they are known codes
	wire logic restore_f_ok = restore_valid & (restore_first <= `OFS_CODE_LAST);
	wire logic restore_s_ok = restore_valid & (restore_second <= `OFS_CODE_LAST);

	// Next stored codes: a configuration write beats a restore
	wire outsel_pkg::func_code_t next_first_setting =
		write_first  ? cfg_code :
		restore_f_ok ? restore_first : first_output_function_setting;
	wire outsel_pkg::func_code_t next_second_setting =
		write_second ? cfg_code :
		restore_s_ok ? restore_second : second_output_function_setting;

	// ----------------------------------------------------------------
	// Setting storage
	// ----------------------------------------------------------------
	// Factory defaults on reset, then held until a legal change
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			first_output_function_setting  <= `OFS_FIRST_DEFAULT;  // RULE1
			second_output_function_setting <= `OFS_SECOND_DEFAULT; // RULE1
			cfg_refused                    <= 1'b0;
		end
		else if (clock_en)
		begin
			first_output_function_setting  <= next_first_setting;  // RULE13
			second_output_function_setting <= next_second_setting; // RULE13
			cfg_refused                    <= write_bad;
		end
	end

	// ----------------------------------------------------------------
	// Function decode per output
	// ----------------------------------------------------------------
	logic first_active;    // First output active level
	logic second_active;   // Second output active level

	// First output decoder
	output_channel u_first
	(
		.code      (first_output_function_setting),
		.heat_dem  (heat_demand),
		.cool_dem  (cool_demand),
		.alarm_act (alarm_active),
		.timer_end (timer_timed_out),
		.timer_run (timer_running),
		.active    (first_active)
	);

	// Second output decoder
	output_channel u_second
	(
		.code      (second_output_function_setting),
		.heat_dem  (heat_demand),                      // RULE5
		.cool_dem  (cool_demand),                      // RULE6
		.alarm_act (alarm_active),
		.timer_end (timer_timed_out),
		.timer_run (timer_running),
		.active    (second_active)
	);

	// ----------------------------------------------------------------
	// Output stage mapping
	// ----------------------------------------------------------------
	// Only the fitted stage is ever driven
	wire logic next_first_relay  = first_active & ~first_logic_sync;   // RULE12
	wire logic next_first_logic  = first_active & first_logic_sync;    // RULE12
	wire logic next_second_relay = second_active & ~second_analog_sync;
	// Inactive analogue stage sits at zero current
	wire logic next_second_curr  = second_active & second_analog_sync; // RULE9

	// Registered drives; all off during reset
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			first_relay_energise  <= 1'b0;
			first_logic_drive     <= 1'b0;
			second_relay_energise <= 1'b0;
			second_current_on     <= 1'b0;
		end
		else if (clock_en)
		begin
			first_relay_energise  <= next_first_relay;
			first_logic_drive     <= next_first_logic;
			second_relay_energise <= next_second_relay;
			second_current_on     <= next_second_curr;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	wire logic first_any  = first_relay_energise | first_logic_drive;
	wire logic second_any = second_relay_energise | second_current_on;

	a_reset_defaults: assert property ( // RULE1
		$past(srst) |-> (first_output_function_setting == `OFS_FIRST_DEFAULT)
			&& (second_output_function_setting == `OFS_SECOND_DEFAULT))
		else $error("settings not at defaults after reset");

	a_disabled_off: assert property ( // RULE2
		$past(clock_en) && ($past(second_output_function_setting) == `OFS_CODE_DISABLED)
			|-> !second_any)
		else $error("disabled output driven");

	a_first_heat: assert property ( // RULE3
		$past(clock_en) && ($past(first_output_function_setting) == `OFS_CODE_HEAT)
			|-> first_any == $past(heat_demand))
		else $error("first output does not follow heat");

	a_first_cool: assert property ( // RULE4
		$past(clock_en) && ($past(first_output_function_setting) == `OFS_CODE_COOL)
			|-> first_any == $past(cool_demand))
		else $error("first output does not follow cool");

	a_second_heat: assert property ( // RULE5
		$past(clock_en) && ($past(second_output_function_setting) == `OFS_CODE_HEAT)
			|-> second_any == $past(heat_demand))
		else $error("second output does not follow heat");

	a_second_cool: assert property ( // RULE6
		$past(clock_en) && ($past(second_output_function_setting) == `OFS_CODE_COOL)
			|-> second_any == $past(cool_demand))
		else $error("second output does not follow cool");

	a_alarm_normal: assert property ( // RULE7
		$past(clock_en) && ($past(second_output_function_setting) == `OFS_CODE_ALARM2)
			|-> second_any == $past(alarm_active[1]))
		else $error("normal alarm sense wrong");

	a_alarm_invert: assert property ( // RULE8
		$past(clock_en) && ($past(first_output_function_setting) == `OFS_CODE_ALARM3_INV)
			|-> first_any == !$past(alarm_active[2]))
		else $error("inverted alarm sense wrong");

	a_analog_zero: assert property ( // RULE9
		$past(clock_en) && $past(second_analog_sync)
			&& ($past(second_output_function_setting) == `OFS_CODE_ALARM1_INV)
			&& $past(alarm_active[0]) |-> !second_current_on && !second_relay_energise)
		else $error("analogue output not at zero current");

	a_timer_end: assert property ( // RULE10
		$past(clock_en) && ($past(second_output_function_setting) == `OFS_CODE_TIMER_END)
			|-> second_any == $past(timer_timed_out))
		else $error("timer end status wrong");

	a_timer_run: assert property ( // RULE11
		$past(clock_en) && ($past(first_output_function_setting) == `OFS_CODE_TIMER_RUN)
			|-> first_any == $past(timer_running))
		else $error("timer run status wrong");

	a_stage_exclusive: assert property ( // RULE12
		!(first_relay_energise && first_logic_drive)
			&& (!first_logic_drive || $past(first_logic_sync)))
		else $error("first output drives unfitted stage");

	a_setting_guard: assert property ( // RULE13
		$past(clock_en) && !$past(config_level) && !$past(restore_valid)
			|-> $stable(first_output_function_setting)
			&& $stable(second_output_function_setting))
		else $error("setting changed outside configuration level");

	// ----------------------------------------------------------------
	// Assertions on further code and output pairs, not all of the remaining ones
	// ----------------------------------------------------------------
	// Both outputs are guarded, not only the one that each check above watches

	a_first_off: assert property ( // RULE2
		$past(clock_en) && ($past(first_output_function_setting) == `OFS_CODE_DISABLED)
			|-> !first_any)
		else $error("disabled first output driven");

	a_first_alarm1: assert property ( // RULE7
		$past(clock_en) && ($past(first_output_function_setting) == `OFS_CODE_ALARM1)
			|-> first_any == $past(alarm_active[0]))
		else $error("first output alarm 1 sense wrong");

	a_first_alarm3: assert property ( // RULE7
		$past(clock_en) && ($past(first_output_function_setting) == `OFS_CODE_ALARM3)
			|-> first_any == $past(alarm_active[2]))
		else $error("first output alarm 3 sense wrong");

	a_second_inv1: assert property ( // RULE8
		$past(clock_en) && ($past(second_output_function_setting) == `OFS_CODE_ALARM1_INV)
			|-> second_any == !$past(alarm_active[0]))
		else $error("second output inverted alarm 1 wrong");

	a_second_inv3: assert property ( // RULE8
		$past(clock_en) && ($past(second_output_function_setting) == `OFS_CODE_ALARM3_INV)
			|-> second_any == !$past(alarm_active[2]))
		else $error("second output inverted alarm 3 wrong");

	a_first_tmr_end: assert property ( // RULE10
		$past(clock_en) && ($past(first_output_function_setting) == `OFS_CODE_TIMER_END)
			|-> first_any == $past(timer_timed_out))
		else $error("first output timer end wrong");

	a_second_tmr_run: assert property ( // RULE11
		$past(clock_en) && ($past(second_output_function_setting) == `OFS_CODE_TIMER_RUN)
			|-> second_any == $past(timer_running))
		else $error("second output timer run wrong");

	a_second_stage: assert property ( // RULE9
		!(second_relay_energise && second_current_on)
			&& (!second_current_on || $past(second_analog_sync)))
		else $error("second output drives unfitted stage");

	a_refuse_locked: assert property ( // RULE13
		$past(clock_en) && $past(cfg_write) && !$past(config_level)
			|-> cfg_refused)
		else $error("locked write not refused");

	a_refuse_unknown: assert property ( // RULE13
		$past(clock_en) && $past(cfg_write) && ($past(cfg_code) > `OFS_CODE_LAST)
			|-> cfg_refused)
		else $error("unknown code write not refused");

	a_write_lands: assert property ( // RULE13
		$past(clock_en) && $past(cfg_write) && $past(config_level)
			&& ($past(cfg_code) <= `OFS_CODE_LAST)
			&& ($past(cfg_target) == outsel_pkg::SEL_FIRST)
			|-> (first_output_function_setting == $past(cfg_code)))
		else $error("accepted write did not land");

endmodule : output_function_selector

// ### core/outsel_pkg.sv
// Types shared by the output function selector files
package outsel_pkg;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef logic [3:0] func_code_t;   // One output's function code
	typedef logic [2:0] alarm_set_t;   // Alarm 3..1 active flags

	// Which output a configuration write addresses
	typedef enum logic {
		SEL_FIRST,
		SEL_SECOND
	} out_select_t;

endpackage : outsel_pkg

// ### core/outsel_regs.svh
// Function codes, defaults and sizes for the output function selector
`ifndef OUTSEL_REGS_SVH
`define OUTSEL_REGS_SVH

// ----------------------------------------------------------------
// Function code width
// ----------------------------------------------------------------
`define OFS_CODE_W          4

// ----------------------------------------------------------------
// Function codes
// ----------------------------------------------------------------
`define OFS_CODE_DISABLED   4'h0
`define OFS_CODE_HEAT       4'h1
`define OFS_CODE_COOL       4'h2
`define OFS_CODE_ALARM1     4'h3
`define OFS_CODE_ALARM2     4'h4
`define OFS_CODE_ALARM3     4'h5
`define OFS_CODE_ALARM1_INV 4'h6
`define OFS_CODE_ALARM2_INV 4'h7
`define OFS_CODE_ALARM3_INV 4'h8
`define OFS_CODE_TIMER_END  4'h9
`define OFS_CODE_TIMER_RUN  4'hA
`define OFS_CODE_LAST       4'hA

// ----------------------------------------------------------------
// Factory defaults
// ----------------------------------------------------------------
`define OFS_FIRST_DEFAULT   4'h1
`define OFS_SECOND_DEFAULT  4'h0

`endif

// ### tb/output_function_selector_tb.sv
// Self-checking testbench for the output function selector
`timescale 1ns/1ps
`include "outsel_regs.svh"

module output_function_selector_tb;

	// ----------------------------------------------------------------
	// Stimulus, observation and score
	// ----------------------------------------------------------------
	logic                   clock;          // 100 MHz clock
	logic                   srst;           // Sync reset
	logic                   clock_en;       // Freeze control
	logic                   heat_demand;    // Loop heat demand
	logic                   cool_demand;    // Loop cool demand
	outsel_pkg::alarm_set_t alarm_active;   // Alarm flags
	logic                   timer_end;      // Timer timed out
	logic                   timer_run;      // Timer running
	logic                   config_level;   // Config access level
	logic                   cfg_write;      // Write strobe
	outsel_pkg::out_select_t cfg_target;    // Output addressed
	outsel_pkg::func_code_t cfg_code;       // Code to store
	logic                   restore_valid;  // Saved codes present
	outsel_pkg::func_code_t restore_first;  // Saved first code
	outsel_pkg::func_code_t restore_second; // Saved second code
	logic                   logic_fit;      // First stage is logic drive
	logic                   analog_fit;     // Second stage is analogue
	logic                   first_relay;    // First relay coil
	logic                   first_logic;    // First logic drive
	logic                   second_relay;   // Second relay coil
	logic                   second_current; // Second current on
	outsel_pkg::func_code_t first_setting;  // Stored first code
	outsel_pkg::func_code_t second_setting; // Stored second code
	logic                   cfg_refused;    // Refusal pulse
	logic                   last_refused;   // Refusal seen on last write
	int                     fail_count;     // Mismatches
	int                     checks_done;    // Comparisons

	output_function_selector uut (
		.clock(clock), .srst(srst), .clock_en(clock_en),
		.heat_demand(heat_demand), .cool_demand(cool_demand), .alarm_active(alarm_active),
		.timer_timed_out(timer_end), .timer_running(timer_run),
		.config_level(config_level), .cfg_write(cfg_write), .cfg_target(cfg_target),
		.cfg_code(cfg_code), .restore_valid(restore_valid), .restore_first(restore_first),
		.restore_second(restore_second), .first_is_logic_pin(logic_fit),
		.second_is_analog_pin(analog_fit), .first_relay_energise(first_relay),
		.first_logic_drive(first_logic), .second_relay_energise(second_relay),
		.second_current_on(second_current), .first_output_function_setting(first_setting),
		.second_output_function_setting(second_setting), .cfg_refused(cfg_refused));

	// ----------------------------------------------------------------
	// Clock
	// ----------------------------------------------------------------
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Compare and score one value
	task automatic check(input string name, input logic [3:0] exp, input logic [3:0] got);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : check

	// One configuration write, refusal captured after the taking edge
	task automatic write_code(input logic tgt, input logic [3:0] code);
		@(posedge clock);
		cfg_write <= 1'b1;
		cfg_target <= outsel_pkg::out_select_t'(tgt);
		cfg_code <= code;
		@(posedge clock);
		cfg_write <= 1'b0;
		#1;
		last_refused = cfg_refused;
	endtask : write_code

	// Expected active level: p = {run, end, alarm[2:0], cool, heat}
	function automatic logic exp_act(input logic [3:0] c, input logic [6:0] p);
		case (c)
			`OFS_CODE_HEAT: return p[0];
			`OFS_CODE_COOL: return p[1];
			`OFS_CODE_ALARM1, `OFS_CODE_ALARM2, `OFS_CODE_ALARM3: return p[c - 4'h1];
			`OFS_CODE_ALARM1_INV, `OFS_CODE_ALARM2_INV, `OFS_CODE_ALARM3_INV: return !p[c - 4'h4];
			`OFS_CODE_TIMER_END: return p[5];
			`OFS_CODE_TIMER_RUN: return p[6];
			default: return 1'b0;
		endcase
	endfunction : exp_act

	// Drive of the fitted stage of one output
	function automatic logic seen(input logic tgt);
		if (tgt == 1'b0)
			return logic_fit ? first_logic : first_relay;
		return analog_fit ? second_current : second_relay;
	endfunction : seen

	// Drive of the stage that is not fitted, which must stay off
	function automatic logic unfit(input logic tgt);
		if (tgt == 1'b0)
			return logic_fit ? first_relay : first_logic;
		return analog_fit ? second_relay : second_current;
	endfunction : unfit

	// Store a code, then walk every input pattern through it
	task automatic sweep(input logic tgt, input logic [3:0] code);
		logic [6:0] p;
		write_code(tgt, code);
		for (int i = 0; i < 128; i++)
		begin
			p = 7'(i);
			@(posedge clock);
			heat_demand <= p[0];
			cool_demand <= p[1];
			alarm_active <= p[4:2];
			timer_end <= p[5];
			timer_run <= p[6];
			@(posedge clock);
			#1;
			check("output drive", {3'h0, exp_act(code, p)}, {3'h0, seen(tgt)});
			check("unfitted stage", 4'h0, {3'h0, unfit(tgt)});
		end
	endtask : sweep

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic scen_defaults();
		check("first setting", 4'h1, first_setting);
		check("second setting", 4'h0, second_setting);
		check("drives", 4'h0, {first_relay, first_logic, second_relay, second_current});
	endtask : scen_defaults

	task automatic scen_functions();
		sweep(1'b1, `OFS_CODE_DISABLED);
		sweep(1'b0, `OFS_CODE_DISABLED);
		sweep(1'b0, `OFS_CODE_HEAT);
		sweep(1'b0, `OFS_CODE_COOL);
		sweep(1'b1, `OFS_CODE_HEAT);
		sweep(1'b1, `OFS_CODE_COOL);
		sweep(1'b0, `OFS_CODE_ALARM1);
		sweep(1'b1, `OFS_CODE_ALARM2);
		sweep(1'b0, `OFS_CODE_ALARM3);
		sweep(1'b1, `OFS_CODE_ALARM1_INV);
		sweep(1'b0, `OFS_CODE_ALARM2_INV);
		sweep(1'b1, `OFS_CODE_ALARM3_INV);
		sweep(1'b0, `OFS_CODE_TIMER_END);
		sweep(1'b1, `OFS_CODE_TIMER_END);
		sweep(1'b1, `OFS_CODE_TIMER_RUN);
		sweep(1'b0, `OFS_CODE_TIMER_RUN);
	endtask : scen_functions

	// Logic and analogue stages fitted, straps given time to sync
	task automatic scen_stages();
		@(posedge clock);
		logic_fit <= 1'b1;
		analog_fit <= 1'b1;
		repeat (4) @(posedge clock);
		sweep(1'b1, `OFS_CODE_ALARM1_INV);
		sweep(1'b0, `OFS_CODE_HEAT);
		sweep(1'b0, `OFS_CODE_ALARM3_INV);
	endtask : scen_stages

	// Access level, bad code, restore and write priority
	task automatic scen_config();
		write_code(1'b0, `OFS_CODE_HEAT);
		check("refused ok write", 4'h0, {3'h0, last_refused});
		config_level <= 1'b0;
		write_code(1'b0, `OFS_CODE_COOL);
		check("refused locked", 4'h1, {3'h0, last_refused});
		check("locked setting", 4'h1, first_setting);
		config_level <= 1'b1;
		write_code(1'b1, 4'hB);
		check("refused bad code", 4'h1, {3'h0, last_refused});
		check("bad code setting", 4'h6, second_setting);
		@(posedge clock);
		restore_first <= `OFS_CODE_TIMER_END;
		restore_second <= `OFS_CODE_TIMER_RUN;
		restore_valid <= 1'b1;
		@(posedge clock);
		#1;
		check("restored first", 4'h9, first_setting);
		check("restored second", 4'hA, second_setting);
		write_code(1'b0, `OFS_CODE_COOL);
		check("write over restore", 4'h2, first_setting);
		check("restore kept", 4'hA, second_setting);
		restore_valid <= 1'b0;
	endtask : scen_config

	// Clock enable low holds the drive, release lets it follow again
	task automatic scen_freeze();
		@(posedge clock);
		clock_en <= 1'b0;
		cool_demand <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
		check("frozen drive", 4'h1, {3'h0, seen(1'b0)});
		@(posedge clock);
		clock_en <= 1'b1;
		@(posedge clock);
		#1;
		check("released drive", 4'h0, {3'h0, seen(1'b0)});
	endtask : scen_freeze

	// ----------------------------------------------------------------
	// Verdict
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude

	// Hang guard
	initial
	begin
		#400000;
		fail_count++;
		$display("unexpected run time: expected finish, seen timeout");
		conclude();
	end

	// Main sequence
	initial
	begin
		fail_count = 0;
		checks_done = 0;
		srst = 1'b1;
		clock_en = 1'b1;
		{heat_demand, cool_demand, timer_end, timer_run} = 4'h0;
		alarm_active = 3'h0;
		config_level = 1'b1;
		cfg_write = 1'b0;
		cfg_target = outsel_pkg::SEL_FIRST;
		cfg_code = 4'h0;
		restore_valid = 1'b0;
		restore_first = 4'h0;
		restore_second = 4'h0;
		logic_fit = 1'b0;
		analog_fit = 1'b0;
		repeat (8) @(posedge clock);
		srst <= 1'b0;
		#1;
		scen_defaults();
		scen_functions();
		scen_stages();
		scen_config();
		scen_freeze();
		conclude();
	end

endmodule : output_function_selector_tb
